//--- baud_gen.sv
/*
 * baud divisor counter producing a one-cycle half-bit enable.
 * assumes the divisor is stable while a frame shifts.
 */
`timescale 1ns/1ps
module baud_gen (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [11:0] baud_divisor,
    output logic half_tick
);
    import spi_pkg::*;

    typedef struct packed {
        logic [11:0] count;
        logic tick;
    } baud_state_t;

    baud_state_t state_reg;
    baud_state_t state_next;

    // half period = divisor + 1 cycles, so bit rate = fclk/(2(d+1))
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.count = divisor_reset;
        end else if (state_reg.count >= baud_divisor) begin
            state_next.count = divisor_reset;
            state_next.tick = 1'b1;
        end else begin
            state_next.count = state_reg.count + 12'h001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign half_tick = state_reg.tick;
endmodule : baud_gen

//--- in_sync.sv
/*
 * two flip-flop synchroniser for the serial input pin.
 * assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module in_sync (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic pin_in,
    output logic pin_sync
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next.first = pin_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_sync = state_reg.second;
endmodule : in_sync

//--- spi_master.sv
/*
 * master-only spi transfer engine with a double-buffered transmitter
 * and a two-level receive buffer; all control and status are ports.
 * assumes software writes and reads the data location by strobes on
 * core_clk and keeps configuration stable while a frame is in flight.
 */
// What this block does
// - transmitter on drives serial_out from shifter
// - receiver optional, enabled by receiver_on
// - receiver on feeds serial_in into shifter
// - transfer clock pin clocks both directions
// - only data writes start a transfer
// - buffered byte loads when shifter ready
// - overflow drops newest byte, keeps older ones
// - rx/tx complete, buffer empty flags as usual
// - frame, overrun, parity flags read zero
// - disabling transmitter or receiver as usual
// - transmit path double buffered
// - receive path one extra buffer level
// - no collision flag, no double speed bit
// - master only, no slave select input
// - polarity and phase pick four spi modes
// - eight bits, selectable order both directions
// - clock rate fclk over 2(divisor+1)
`timescale 1ns/1ps
module spi_master (
    input wire logic core_clk,
    input wire logic resetn,
    input spi_pkg::spi_cfg_t cfg,
    input wire logic data_write,
    input wire logic [7:0] data_write_byte,
    input wire logic data_read,
    input wire logic tx_complete_clear,
    input wire logic serial_in_pin,
    output logic [7:0] data_read_byte,
    output spi_pkg::spi_status_t status,
    output spi_pkg::spi_pins_t pins,
    output logic rx_complete_irq,
    output logic tx_complete_irq,
    output logic tx_empty_irq
);
    import spi_pkg::*;

    typedef struct packed {
        shift_state_t phase;
        // holding register in front of the shifter
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic [3:0] bit_count;
        // two-entry receive queue, rx_buf0 is the oldest
        logic [7:0] rx_buf0;
        logic [7:0] rx_buf1;
        logic [1:0] rx_level;
        logic tx_done;
        logic sck;
        logic sdo;
        logic sdo_oe;
        logic sck_oe;
        logic [7:0] read_byte;
        spi_status_t flags;
        logic txe_irq;
    } master_state_t;

    // power-on contents; serial_out starts high, buffer empty
    localparam master_state_t state_reset = '{
        phase: st_idle,
        tx_buf: byte_reset,
        tx_full: 1'b0,
        tx_shift: byte_reset,
        rx_shift: byte_reset,
        bit_count: bit_count_reset,
        rx_buf0: byte_reset,
        rx_buf1: byte_reset,
        rx_level: 2'h0,
        tx_done: 1'b0,
        sck: 1'b0,
        sdo: 1'b1,
        sdo_oe: 1'b0,
        sck_oe: 1'b0,
        read_byte: byte_reset,
        flags: '{tx_buffer_empty_flag: 1'b1, default: 1'b0},
        txe_irq: 1'b0
    };

    master_state_t state_reg;
    master_state_t state_next;
    // half-bit strobe, divisor+1 cycles apart
    logic half_tick;
    logic serial_in_sync;
    logic shifting;

    // pick the outgoing bit for the chosen order
    function automatic logic out_bit(input logic [7:0] v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction : out_bit

    // shift away the sent bit for the chosen order
    function automatic logic [7:0] shift_out(input logic [7:0] v,
                                             input logic lsb);
        shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
    endfunction : shift_out

    // place a sampled bit for the chosen order
    function automatic logic [7:0] shift_in(input logic [7:0] v,
                                            input logic lsb, input logic b);
        shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shift_in

    // registered status view of the buffers
    function automatic spi_status_t flags_of(input logic [1:0] level,
                                             input logic full,
                                             input logic done);
        flags_of.rx_complete_flag = |level;
        flags_of.tx_complete_flag = done;
        flags_of.tx_buffer_empty_flag = !full;
        flags_of.frame_error_flag = 1'b0;
        flags_of.data_overrun_flag = 1'b0;
        flags_of.parity_error_flag = 1'b0;
    endfunction : flags_of

    assign shifting = state_reg.phase != st_idle;

    baud_gen u_baud (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(shifting),
        .baud_divisor(cfg.baud_divisor),
        .half_tick(half_tick)
    );

    // only the pin crosses domains; cfg is on core_clk
    in_sync u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(serial_in_pin),
        .pin_sync(serial_in_sync)
    );

    always_comb begin
        logic sample_now;
        logic frame_end;
        logic rx_push;
        logic [7:0] rx_word;
        sample_now = 1'b0;
        frame_end = 1'b0;
        rx_push = 1'b0;
        rx_word = state_reg.rx_shift;
        state_next = state_reg;

        // pin ownership follows the transmitter enable
        state_next.sdo_oe = cfg.transmitter_on;
        state_next.sck_oe = cfg.transmitter_on;

        // read pops the oldest byte from the receive buffer
        if (data_read && state_reg.rx_level != 2'h0) begin
            state_next.rx_buf0 = state_reg.rx_buf1;
            state_next.rx_level = state_reg.rx_level - 2'h1;
        end

        // data write queues a byte; only this starts transfers
        if (data_write && cfg.transmitter_on && !state_reg.tx_full) begin
            state_next.tx_buf = data_write_byte;
            state_next.tx_full = 1'b1;
        end

        case (state_reg.phase)
            st_idle: begin
                state_next.sck = cfg.clock_polarity_bit;
                if (state_reg.tx_full && cfg.transmitter_on) begin
                    state_next.tx_shift = state_reg.tx_buf;
                    // writes are refused while full, so it frees
                    state_next.tx_full = 1'b0;
                    state_next.bit_count = bit_count_reset;
                    state_next.phase = st_lead;
                    state_next.tx_done = 1'b0;
                    // phase 0 sets up the first bit before the lead edge
                    state_next.sdo = out_bit(state_reg.tx_buf,
                                             cfg.bit_order_bit);
                end
            end
            st_lead: begin
                if (half_tick) begin
                    state_next.sck = ~cfg.clock_polarity_bit;
                    state_next.phase = st_trail;
                    // phase 1 sets up each bit on the lead edge
                    if (cfg.clock_phase_bit) begin
                        state_next.sdo = out_bit(state_reg.tx_shift,
                                                 cfg.bit_order_bit);
                    end else begin
                        sample_now = 1'b1;
                    end
                end
            end
            st_trail: begin
                if (half_tick) begin
                    state_next.sck = cfg.clock_polarity_bit;
                    if (cfg.clock_phase_bit) begin
                        sample_now = 1'b1;
                    end
                    state_next.tx_shift = shift_out(state_reg.tx_shift,
                                                    cfg.bit_order_bit);
                    state_next.bit_count = state_reg.bit_count + 4'h1;
                    // frame ends on the eighth trailing edge
                    if (state_reg.bit_count == 4'(frame_bits - 1)) begin
                        frame_end = 1'b1;
                        state_next.phase = st_idle;
                    end else begin
                        state_next.phase = st_lead;
                        // phase 0 sets up the next bit here
                        if (!cfg.clock_phase_bit) begin
                            state_next.sdo = out_bit(
                                shift_out(state_reg.tx_shift,
                                          cfg.bit_order_bit),
                                cfg.bit_order_bit);
                        end
                    end
                end
            end
            default: begin
                // stray encoding falls back to idle
                state_next.phase = st_idle;
            end
        endcase

        // input lags two sync flops; divisor 2 or more
        if (sample_now && cfg.receiver_on) begin
            state_next.rx_shift = shift_in(state_reg.rx_shift,
                                           cfg.bit_order_bit,
                                           serial_in_sync);
            rx_word = state_next.rx_shift;
        end

        // a finished frame enters the buffer unless it is full
        if (frame_end && cfg.receiver_on) begin
            rx_push = 1'b1;
        end
        if (rx_push && state_next.rx_level != rx_level_max) begin
            if (state_next.rx_level == 2'h0) begin
                state_next.rx_buf0 = rx_word;
            end else begin
                state_next.rx_buf1 = rx_word;
            end
            state_next.rx_level = state_next.rx_level + 2'h1;
        end // overflowing newest frame is dropped

        // tx complete: frame out with nothing queued; set wins clear
        if (tx_complete_clear) begin
            state_next.tx_done = 1'b0;
        end
        // a byte written in the same cycle counts as waiting
        if (frame_end && !state_next.tx_full) begin
            state_next.tx_done = 1'b1;
        end

        // disabling flushes as in the asynchronous mode
        if (!cfg.transmitter_on) begin
            state_next.phase = st_idle;
            state_next.tx_full = 1'b0;
            state_next.sck = cfg.clock_polarity_bit;
        end
        if (!cfg.receiver_on) begin
            state_next.rx_level = 2'h0;
        end

        state_next.read_byte = state_next.rx_buf0;

        // flags are registered so every output is a flop
        state_next.flags = flags_of(state_next.rx_level, state_next.tx_full,
                                    state_next.tx_done);
        state_next.txe_irq = !state_next.tx_full && state_next.sdo_oe;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= state_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    // pins and status straight from registers
    always_comb begin
        data_read_byte = state_reg.read_byte;
        status = state_reg.flags;
        pins.serial_out = state_reg.sdo;
        pins.serial_out_oe = state_reg.sdo_oe;
        pins.transfer_clock = state_reg.sck;
        pins.transfer_clock_oe = state_reg.sck_oe;
        rx_complete_irq = state_reg.flags.rx_complete_flag;
        tx_complete_irq = state_reg.tx_done;
        tx_empty_irq = state_reg.txe_irq;
    end
endmodule : spi_master

//--- spi_master_checker.sv
/*
 * port-level assertions for spi_master.
 * assumes it is bound to every spi_master instance.
 */
`timescale 1ns/1ps
module spi_master_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input spi_pkg::spi_cfg_t cfg,
    input wire logic data_write,
    input spi_pkg::spi_status_t status,
    input spi_pkg::spi_pins_t pins
);
    import spi_pkg::*;
    logic [12:0] gap_reg;
    logic sck_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // cycles since the transfer clock last moved
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= 13'h0000;
            sck_reg <= 1'b0;
        end else begin
            sck_reg <= pins.transfer_clock;
            if (pins.transfer_clock != sck_reg) begin
                gap_reg <= 13'h0000;
            end else if (gap_reg != 13'h1fff) begin
                gap_reg <= gap_reg + 13'h0001;
            end
        end
    end
    AST_ZERO_FLAGS: assert property (
        !(status.frame_error_flag || status.data_overrun_flag
          || status.parity_error_flag))
        else $error("receiver error flag set");
    AST_OUT_OE: assert property (
        $past(resetn) |-> pins.serial_out_oe == $past(cfg.transmitter_on))
        else $error("serial out enable wrong");
    AST_CLK_OE: assert property (
        $past(resetn) |-> pins.transfer_clock_oe == $past(cfg.transmitter_on))
        else $error("transfer clock enable wrong");
    AST_WRITE_QUEUED: assert property (
        data_write && cfg.transmitter_on && status.tx_buffer_empty_flag
        |=> !status.tx_buffer_empty_flag)
        else $error("write not queued");
    AST_TX_OFF: assert property (
        !cfg.transmitter_on |=> status.tx_buffer_empty_flag)
        else $error("buffer kept while transmitter off");
    AST_HALF_BIT: assert property (
        pins.transfer_clock != sck_reg |-> gap_reg >= {1'b0, cfg.baud_divisor})
        else $error("half bit too short");
    AST_TXC_EMPTY: assert property (
        $rose(status.tx_complete_flag) |-> status.tx_buffer_empty_flag)
        else $error("tx complete with byte queued");
    AST_RXC_ON: assert property (
        $rose(status.rx_complete_flag) |-> cfg.receiver_on)
        else $error("byte received with receiver off");
    AST_CLK_IDLE: assert property (
        $rose(status.tx_complete_flag)
        |-> pins.transfer_clock == cfg.clock_polarity_bit)
        else $error("transfer clock not idle at frame end");
endmodule : spi_master_checker
bind spi_master spi_master_checker chk_u (.core_clk(core_clk),
    .resetn(resetn), .cfg(cfg), .data_write(data_write),
    .status(status), .pins(pins));

//--- spi_pkg.sv
/*
 * shared types and constants for the master spi transfer block.
 * assumes a single 40 MHz core clock and no register bus.
 */
package spi_pkg;
    localparam int unsigned core_clk_mhz = 40;
    localparam int unsigned frame_bits = 8;
    localparam logic [11:0] divisor_reset = 12'h000;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam logic [3:0] bit_count_reset = 4'h0;
    localparam logic [1:0] rx_level_max = 2'h2;

    // software-facing configuration
    typedef struct packed {
        logic transmitter_on;
        logic receiver_on;
        logic clock_polarity_bit;
        logic clock_phase_bit;
        logic bit_order_bit;
        logic [11:0] baud_divisor;
    } spi_cfg_t;

    // status flags as seen in status_control_a
    typedef struct packed {
        logic rx_complete_flag;
        logic tx_complete_flag;
        logic tx_buffer_empty_flag;
        logic frame_error_flag;
        logic data_overrun_flag;
        logic parity_error_flag;
    } spi_status_t;

    // serial pins; output enables are high while driven
    typedef struct packed {
        logic serial_out;
        logic serial_out_oe;
        logic transfer_clock;
        logic transfer_clock_oe;
    } spi_pins_t;

    typedef enum logic [1:0] {st_idle, st_lead, st_trail} shift_state_t;
endpackage : spi_pkg

//--- spi_slave_model.sv
/*
 * behavioural shift-register slave on the far side of the pins.
 * assumes the bench gives it the same mode and bit order as the master.
 */
`timescale 1ns/1ps
module spi_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    output logic miso
);
    logic [7:0] sr;
    logic lead;
    int n_edges;
    task load(input logic [7:0] b);
        sr = b;
        miso = lsb ? b[0] : b[7];
        n_edges = 0;
    endtask : load
    // returns the previous frame's byte, like a plain shift register
    always @(sclk) begin
        lead = (sclk != cpol);
        n_edges++;
        if (lead ^ cpha) begin
            sr = lsb ? {mosi, sr[7:1]} : {sr[6:0], mosi};
        end else begin
            miso = lsb ? sr[0] : sr[7];
        end
    end
endmodule : spi_slave_model

//--- testbench.sv
/*
 * self-checking bench for spi_master against a shift-register slave.
 * assumes a 40 MHz core clock and divisor 3 for all transfers.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin \
    n_compared++; \
    if ((a) !== (b)) begin \
        n_errors++; \
        $display("[ERR] %0t got %h exp %h", $time, a, b); \
    end \
end
module testbench;
    import spi_pkg::*;
    logic core_clk, resetn, data_write, data_read, tx_complete_clear, miso;
    logic rx_complete_irq, tx_complete_irq, tx_empty_irq;
    logic [7:0] data_write_byte, data_read_byte;
    spi_cfg_t cfg;
    spi_status_t status;
    spi_pins_t pins;
    int n_errors, n_compared;
    spi_master dut_u (.core_clk(core_clk), .resetn(resetn), .cfg(cfg),
        .data_write(data_write), .data_write_byte(data_write_byte),
        .data_read(data_read), .tx_complete_clear(tx_complete_clear),
        .serial_in_pin(miso), .data_read_byte(data_read_byte),
        .status(status), .pins(pins), .rx_complete_irq(rx_complete_irq),
        .tx_complete_irq(tx_complete_irq), .tx_empty_irq(tx_empty_irq));
    spi_slave_model slave_u (.sclk(pins.transfer_clock),
        .mosi(pins.serial_out), .cpol(cfg.clock_polarity_bit),
        .cpha(cfg.clock_phase_bit), .lsb(cfg.bit_order_bit), .miso(miso));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task end_sim;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // 0 buffer empty, 1 tx complete, 2 rx complete
    task wt(input int s);
        logic f;
        for (int i = 0; i < 3000; i++) begin
            @(negedge core_clk);
            f = s == 0 ? status.tx_buffer_empty_flag :
                s == 1 ? status.tx_complete_flag : status.rx_complete_flag;
            if (f === 1'b1) return;
        end
        n_errors++;
        $display("[ERR] %0t flag %h exp %h", $time, s, 1);
    endtask : wt
    task wr(input logic [7:0] b);
        wt(0);
        @(posedge core_clk);
        data_write <= 1'b1;
        data_write_byte <= b;
        @(posedge core_clk);
        data_write <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] e);
        wt(2);
        `CHK(data_read_byte, e)
        `CHK(rx_complete_irq, 1'b1)
        @(posedge core_clk);
        data_read <= 1'b1;
        @(posedge core_clk);
        data_read <= 1'b0;
    endtask : rd
    task xfer(input logic [7:0] m, input logic [7:0] s);
        @(posedge core_clk);
        tx_complete_clear <= 1'b1;
        @(posedge core_clk);
        tx_complete_clear <= 1'b0;
        slave_u.load(s);
        wr(m);
        wt(1);
    endtask : xfer
    initial begin
        #1_000_000;
        n_errors++;
        end_sim;
    end
    initial begin
        cfg = '0;
        cfg.transmitter_on = 1'b1;
        cfg.receiver_on = 1'b1;
        {data_write, data_read, tx_complete_clear} = 3'h0;
        data_write_byte = 8'h00;
        n_errors = 0;
        n_compared = 0;
        resetn = 1'b0;
        slave_u.load(8'h00);
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        cfg.baud_divisor <= 12'h003;
        for (int m = 0; m < 8; m++) begin
            repeat (8) @(posedge core_clk);
            {cfg.clock_polarity_bit, cfg.clock_phase_bit,
             cfg.bit_order_bit} <= m[2:0];
            repeat (8) @(posedge core_clk);
            xfer(8'h3a + 8'(m), 8'hc5 - 8'(m));
            `CHK(slave_u.sr, 8'h3a + 8'(m))
            `CHK(slave_u.n_edges, 16)
            `CHK(tx_complete_irq, 1'b1)
            `CHK(tx_empty_irq, 1'b1)
            rd(8'hc5 - 8'(m));
        end
        $display("test 1 done");
        xfer(8'h00, 8'h00);
        rd(8'h00);
        slave_u.load(8'h11);
        wr(8'h22);
        wr(8'h33);
        @(negedge core_clk);
        `CHK(status.tx_buffer_empty_flag, 1'b0)
        wr(8'h44);
        wt(1);
        rd(8'h11);
        rd(8'h22);
        repeat (4) @(negedge core_clk);
        `CHK(status.rx_complete_flag, 1'b0)
        $display("test 2 done");
        @(posedge core_clk);
        cfg.receiver_on <= 1'b0;
        xfer(8'h69, 8'h5a);
        `CHK(slave_u.sr, 8'h69)
        `CHK(status.rx_complete_flag, 1'b0)
        @(posedge core_clk);
        cfg.receiver_on <= 1'b1;
        $display("test 3 done");
        cfg.transmitter_on <= 1'b0;
        repeat (4) @(negedge core_clk);
        slave_u.load(8'h00);
        wr(8'h77);
        repeat (100) @(negedge core_clk);
        `CHK(slave_u.n_edges, 0)
        `CHK(pins.serial_out_oe, 1'b0)
        `CHK(status.tx_buffer_empty_flag, 1'b1)
        `CHK(tx_empty_irq, 1'b0)
        `CHK(pins.transfer_clock_oe, 1'b0)
        $display("test 4 done");
        end_sim;
    end
endmodule : testbench
